/* rtl/level_pll_ctrl.v */
// digitizer offset, level loop and line-locked pll control with serial register port
//
// Notes on behaviour
// RULE_01: each channel keeps a 6-bit signed coarse offset, -32..+31, driven to analog.
// RULE_02: each channel adds its own 10-bit signed fine offset, -512..+511, after conversion.
// RULE_03: level loop averages pixels and steers measured level toward fine offset value.
// RULE_04: level loop on/off comes from a control bit at subaddress 26h.
// RULE_05: host places the internal level pulse (31h) after the clamp pulse.
// RULE_06: with external clamp, fine clamp and level loop start on its leading edge.
// RULE_07: the external clamp pulse should be kept as long as practical.
// RULE_08: three 10-bit sample streams share one pll-derived clock, 12 to 90 MHz.
// RULE_09: sample clock source selects internal pll or external pixel clock.
// RULE_10: pll reference is the hsync pin or the slicer-recovered hsync.
// RULE_11: while line-hold is asserted the pll holds frequency and stops tracking.
// RULE_12: fine clamp is off for the whole line-hold interval.
// RULE_13: 12-bit feedback divide: upper 8 from 01h[7:0], lower 4 from 02h[7:4].
// RULE_14: 3-bit pump current select sits in 03h[5:3].
// RULE_15: 2-bit band in 03h[7:6]: 00 ultra-low, 01 low, 10 medium.
// RULE_16: sample phase in 32 steps of 11.25 degrees from 04h.
// RULE_17: host programs recommended divide, range and pump values per format.
// RULE_18: offset-corrected sample saturates to 0..1023, never wraps.
`include "level_pll_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module level_pll_ctrl #(
    parameter       CH         = 3,
    parameter       SW         = 10,
    parameter       FIFO_DEPTH = 8,
    parameter [6:0] DEV_ADDR   = 7'h2a   // arbitrary value
) (
    // clock and reset
    input  wire              i_clk,
    input  wire              i_reset,
    // serial control bus pins
    input  wire              i_scl,
    input  wire              i_sda,
    output reg               o_sda_q,
    output reg               o_sda_oe_n_q,
    // sync and clamp pins
    input  wire              i_hsync_pin,
    input  wire              i_hsync_sliced,
    input  wire              i_line_hold,
    input  wire              i_ext_clamp,
    // digitized samples in
    input  wire              i_sample_valid,
    input  wire [CH*SW-1:0]  i_sample_data,
    output wire              o_sample_ready,
    // corrected samples out
    output wire              o_out_valid,
    output wire [CH*SW-1:0]  o_out_data,
    input  wire              i_out_ready,
    // analog and pll controls
    output reg  [CH*6-1:0]   o_coarse_offset_q,
    output wire [11:0]       o_feedback_divide_count,
    output wire [2:0]        o_pump_current_select,
    output reg  [1:0]        o_band_q,
    output wire [4:0]        o_phase_select,
    output wire              o_post_divide,
    output wire              o_ext_pixel_clock,
    output reg               o_pll_ref_q,
    output reg               o_pll_hold_q,
    output reg               o_fine_clamp_q,
    output reg               o_level_pulse_q
);
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_DEV  = 3'h1;
    localparam [2:0] ST_ACK  = 3'h2;
    localparam [2:0] ST_SUB  = 3'h3;
    localparam [2:0] ST_WR   = 3'h4;
    localparam [2:0] ST_RD   = 3'h5;
    localparam [2:0] ST_RACK = 3'h6;

    // register storage
    reg  [7:0]       div_upper_q;
    reg  [7:0]       div_lower_q;
    reg  [7:0]       range_pump_q;
    reg  [7:0]       phase_post_q;
    reg  [7:0]       level_ctrl_q;
    reg  [7:0]       level_place_q;
    reg  [7:0]       source_ctrl_q;
    reg  [CH*SW-1:0] fine_q;
    reg  [CH*SW-1:0] avg_q;

    // pin synchronisers
    reg  [1:0]       scl_s;
    reg  [1:0]       sda_s;
    reg  [1:0]       hs_pin_s;
    reg  [1:0]       hs_slc_s;
    reg  [1:0]       hold_s;
    reg  [1:0]       clamp_s;
    reg              scl_p;
    reg              sda_p;
    reg              ref_p;
    reg              clamp_p;

    // serial port state
    reg  [2:0]       st_q;
    reg  [2:0]       after_q;
    reg  [2:0]       bit_q;
    reg  [7:0]       shift_q;
    reg  [7:0]       sub_q;
    reg              ackp_q;
    reg  [7:0]       rdata;

    // level window state
    reg  [7:0]       line_cnt_q;
    reg  [7:0]       clamp_cnt_q;
    reg              win_q;
    reg  [4:0]       wcnt_q;

    wire scl       = scl_s[1];
    wire sda       = sda_s[1];
    wire scl_rise  = scl & ~scl_p;
    wire scl_fall  = ~scl & scl_p;
    wire bus_start = scl & scl_p & sda_p & ~sda;
    wire bus_stop  = scl & scl_p & ~sda_p & sda;
    wire [7:0] rx_byte = {shift_q[6:0], sda};

    wire ext_clamp_mode = source_ctrl_q[`SRC_EXT_CLAMP_BIT];
    wire level_on       = level_ctrl_q[`LEVEL_ENABLE_BIT];                    // [RULE_04]
    wire ref_now        = source_ctrl_q[`SRC_SLICED_BIT] ? hs_slc_s[1]
                                                         : hs_pin_s[1];       // [RULE_10]
    wire ref_rise       = ref_now & ~ref_p;
    wire clamp_rise     = clamp_s[1] & ~clamp_p;
    wire accept         = i_sample_valid & o_sample_ready;
    wire win_last       = win_q & accept & (wcnt_q == `LEVEL_WIN_SAMPLES - 5'h01);
    // external clamp edge starts the window; placement ignored
    wire win_start      = ext_clamp_mode ? clamp_rise                         // [RULE_06]
                                         : (line_cnt_q == level_place_q);
    wire [CH*SW-1:0] corrected;

    assign o_feedback_divide_count = {div_upper_q,
                                      div_lower_q[`DIV_LOWER_MSB:`DIV_LOWER_LSB]}; // [RULE_13]
    assign o_pump_current_select = range_pump_q[`PUMP_MSB:`PUMP_LSB];          // [RULE_14]
    assign o_phase_select    = phase_post_q[`PHASE_MSB:`PHASE_LSB];           // [RULE_16]
    assign o_post_divide     = phase_post_q[`POST_DIV_BIT];
    assign o_ext_pixel_clock = source_ctrl_q[`SRC_EXT_CLK_BIT];               // [RULE_09]

    // register readback
    always @* begin
        rdata = 8'h00;
        case (sub_q)
            `REG_DIV_UPPER:   rdata = div_upper_q;
            `REG_DIV_LOWER:   rdata = div_lower_q;
            `REG_RANGE_PUMP:  rdata = range_pump_q;
            `REG_PHASE_POST:  rdata = phase_post_q;
            `REG_LEVEL_CTRL:  rdata = level_ctrl_q;
            `REG_LEVEL_PLACE: rdata = level_place_q;
            `REG_SOURCE_CTRL: rdata = source_ctrl_q;
            `REG_STATUS:      rdata = {6'h00, win_q, hold_s[1]};
            `REG_LEVEL_MEAS:  rdata = avg_q[SW-1:SW-8];
            default: begin
                if (sub_q >= `REG_COARSE_BASE && sub_q < `REG_COARSE_BASE + CH)
                    rdata = {2'h0, o_coarse_offset_q[(sub_q - `REG_COARSE_BASE)*6 +: 6]};
                else if (sub_q >= `REG_FINE_HI_BASE && sub_q < `REG_FINE_HI_BASE + CH)
                    rdata = {6'h00, fine_q[(sub_q - `REG_FINE_HI_BASE)*SW + 8 +: 2]};
                else if (sub_q >= `REG_FINE_LO_BASE && sub_q < `REG_FINE_LO_BASE + CH)
                    rdata = fine_q[(sub_q - `REG_FINE_LO_BASE)*SW +: 8];
            end
        endcase
    end

    // synchronisers and edge history
    always @(posedge i_clk) begin
        if (i_reset) begin
            scl_s    <= 2'h3;
            sda_s    <= 2'h3;
            hs_pin_s <= 2'h0;
            hs_slc_s <= 2'h0;
            hold_s   <= 2'h0;
            clamp_s  <= 2'h0;
            scl_p    <= 1'b1;
            sda_p    <= 1'b1;
            ref_p    <= 1'b0;
            clamp_p  <= 1'b0;
        end else begin
            scl_s    <= {scl_s[0], i_scl};
            sda_s    <= {sda_s[0], i_sda};
            hs_pin_s <= {hs_pin_s[0], i_hsync_pin};
            hs_slc_s <= {hs_slc_s[0], i_hsync_sliced};
            hold_s   <= {hold_s[0], i_line_hold};
            clamp_s  <= {clamp_s[0], i_ext_clamp};
            scl_p    <= scl;
            sda_p    <= sda;
            ref_p    <= ref_now;
            clamp_p  <= clamp_s[1];
        end
    end

    // serial slave: subaddress, then data with auto increment
    always @(posedge i_clk) begin
        if (i_reset) begin
            st_q              <= ST_IDLE;
            after_q           <= ST_IDLE;
            bit_q             <= 3'h0;
            shift_q           <= 8'h00;
            sub_q             <= 8'h00;
            ackp_q            <= 1'b0;
            o_sda_q           <= 1'b0;
            o_sda_oe_n_q      <= 1'b1;
            div_upper_q       <= `RST_DIV_UPPER;
            div_lower_q       <= `RST_DIV_LOWER;
            range_pump_q      <= `RST_RANGE_PUMP;
            phase_post_q      <= `RST_PHASE_POST;
            level_ctrl_q      <= `RST_LEVEL_CTRL;
            level_place_q     <= `RST_LEVEL_PLACE;
            source_ctrl_q     <= `RST_SOURCE_CTRL;
            o_coarse_offset_q <= {(CH*6){1'b0}};
            fine_q            <= {(CH*SW){1'b0}};
        end else if (bus_start) begin
            st_q         <= ST_DEV;
            bit_q        <= 3'h0;
            o_sda_oe_n_q <= 1'b1;
        end else if (bus_stop) begin
            st_q         <= ST_IDLE;
            o_sda_oe_n_q <= 1'b1;
        end else begin
            case (st_q)
                ST_DEV, ST_SUB, ST_WR: begin
                    if (scl_rise) begin
                        shift_q <= rx_byte;
                        bit_q   <= bit_q + 3'h1;
                        if (bit_q == 3'h7) begin
                            st_q   <= ST_ACK;
                            ackp_q <= 1'b0;
                            if (st_q == ST_DEV) begin
                                if (rx_byte[7:1] != DEV_ADDR)
                                    st_q <= ST_IDLE;
                                after_q <= rx_byte[0] ? ST_RD : ST_SUB;
                            end else if (st_q == ST_SUB) begin
                                sub_q   <= rx_byte;
                                after_q <= ST_WR;
                            end else begin
                                sub_q   <= sub_q + 8'h01;
                                after_q <= ST_WR;
                                case (sub_q)
                                    `REG_DIV_UPPER:   div_upper_q   <= rx_byte;
                                    `REG_DIV_LOWER:   div_lower_q   <= rx_byte;
                                    `REG_RANGE_PUMP:  range_pump_q  <= rx_byte;
                                    `REG_PHASE_POST:  phase_post_q  <= rx_byte;
                                    `REG_LEVEL_CTRL:  level_ctrl_q  <= rx_byte;
                                    `REG_LEVEL_PLACE: level_place_q <= rx_byte;
                                    `REG_SOURCE_CTRL: source_ctrl_q <= rx_byte;
                                    default: begin
                                        if (sub_q >= `REG_COARSE_BASE
                                                && sub_q < `REG_COARSE_BASE + CH)
                                            o_coarse_offset_q[(sub_q - `REG_COARSE_BASE)*6 +: 6]
                                                <= rx_byte[5:0];                     // [RULE_01]
                                        else if (sub_q >= `REG_FINE_HI_BASE
                                                && sub_q < `REG_FINE_HI_BASE + CH)
                                            fine_q[(sub_q - `REG_FINE_HI_BASE)*SW + 8 +: 2]
                                                <= rx_byte[1:0];
                                        else if (sub_q >= `REG_FINE_LO_BASE
                                                && sub_q < `REG_FINE_LO_BASE + CH)
                                            fine_q[(sub_q - `REG_FINE_LO_BASE)*SW +: 8]
                                                <= rx_byte;
                                    end
                                endcase
                            end
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        if (!ackp_q) begin
                            ackp_q       <= 1'b1;
                            o_sda_oe_n_q <= 1'b0;
                        end else begin
                            ackp_q       <= 1'b0;
                            st_q         <= after_q;
                            bit_q        <= 3'h0;
                            o_sda_oe_n_q <= 1'b1;
                            if (after_q == ST_RD) begin
                                shift_q      <= rdata;
                                o_sda_oe_n_q <= rdata[7];
                            end
                        end
                    end
                end
                ST_RD: begin
                    if (scl_fall) begin
                        bit_q <= bit_q + 3'h1;
                        if (bit_q == 3'h7) begin
                            o_sda_oe_n_q <= 1'b1;
                            st_q         <= ST_RACK;
                            ackp_q       <= 1'b0;
                            sub_q        <= sub_q + 8'h01;
                        end else begin
                            shift_q      <= {shift_q[6:0], 1'b0};
                            o_sda_oe_n_q <= shift_q[6];
                        end
                    end
                end
                ST_RACK: begin
                    // master nack ends the read; ack fetches the next byte
                    if (scl_rise) begin
                        if (sda)
                            st_q <= ST_IDLE;
                        else
                            ackp_q <= 1'b1;
                    end else if (scl_fall && ackp_q) begin
                        ackp_q       <= 1'b0;
                        st_q         <= ST_RD;
                        bit_q        <= 3'h0;
                        shift_q      <= rdata;
                        o_sda_oe_n_q <= rdata[7];
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // pll reference, hold, band and clamp timing
    always @(posedge i_clk) begin
        if (i_reset) begin
            o_pll_ref_q     <= 1'b0;
            o_pll_hold_q    <= 1'b0;
            o_band_q        <= `BAND_ULTRA_LOW;
            o_fine_clamp_q  <= 1'b0;
            o_level_pulse_q <= 1'b0;
            line_cnt_q      <= 8'hff;
            clamp_cnt_q     <= 8'h00;
            win_q           <= 1'b0;
            wcnt_q          <= 5'h00;
        end else begin
            // the pll coasts on its own while hold is high; reference is frozen
            o_pll_hold_q <= hold_s[1];                                        // [RULE_11]
            if (!hold_s[1])
                o_pll_ref_q <= ref_now;                                       // [RULE_11]
            // reserved code 11 falls back to the medium band
            o_band_q <= (range_pump_q[`RANGE_MSB:`RANGE_LSB] == 2'h3) ? `BAND_MEDIUM
                        : range_pump_q[`RANGE_MSB:`RANGE_LSB];                // [RULE_15]
            if (ref_rise && !hold_s[1]) begin
                line_cnt_q  <= 8'h00;
                clamp_cnt_q <= `CLAMP_LEN_CYCLES;
            end else begin
                if (line_cnt_q != 8'hff)
                    line_cnt_q <= line_cnt_q + 8'h01;
                if (clamp_cnt_q != 8'h00)
                    clamp_cnt_q <= clamp_cnt_q - 8'h01;
            end
            o_fine_clamp_q <= ~hold_s[1] & (ext_clamp_mode ? clamp_s[1]
                                                           : (clamp_cnt_q != 8'h00)); // [RULE_12]
            if (win_last) begin
                win_q  <= 1'b0;
                wcnt_q <= 5'h00;
            end else if (!win_q && level_on && win_start) begin
                win_q  <= 1'b1;
                wcnt_q <= 5'h00;
            end else if (win_q && accept) begin
                wcnt_q <= wcnt_q + 5'h01;
            end
            o_level_pulse_q <= win_q;
        end
    end

    // per-channel fine offset, saturation and level loop
    genvar g;
    generate
        for (g = 0; g < CH; g = g + 1) begin : chan
            reg  [13:0]       sum_q;
            reg  signed [9:0] corr_q;
            wire [SW-1:0]     smp    = i_sample_data[g*SW +: SW];
            wire signed [9:0] fine   = fine_q[g*SW +: SW];
            wire signed [9:0] offs   = level_on ? corr_q : fine;              // [RULE_02]
            wire signed [11:0] sum_w = $signed({2'b00, smp}) + {{2{offs[9]}}, offs};
            wire [SW-1:0]     sat    = sum_w[11] ? 10'h000
                                     : (sum_w[10] ? 10'h3ff : sum_w[9:0]);   // [RULE_18]
            wire [13:0]       acc    = sum_q + {4'h0, sat};
            wire signed [11:0] err   = {{2{fine[9]}}, fine} - $signed({2'b00, acc[13:4]});
            wire signed [11:0] nxt   = $signed({{2{corr_q[9]}}, corr_q}) + (err >>> 2);
            assign corrected[g*SW +: SW] = sat;                               // [RULE_08]
            always @(posedge i_clk) begin
                if (i_reset) begin
                    sum_q  <= 14'h0000;
                    corr_q <= 10'sh000;
                    avg_q[g*SW +: SW] <= {SW{1'b0}};
                end else begin
                    if (!win_q)
                        sum_q <= 14'h0000;
                    else if (accept)
                        sum_q <= acc;
                    if (!level_on) begin
                        corr_q <= fine;
                    end else if (win_last) begin
                        // integrate a quarter of the error; clip keeps the offset in range
                        avg_q[g*SW +: SW] <= acc[13:4];                       // [RULE_03]
                        if (nxt > 12'sd511)
                            corr_q <= 10'sh1ff;
                        else if (nxt < -12'sd512)
                            corr_q <= 10'sh200;
                        else
                            corr_q <= nxt[9:0];                               // [RULE_03]
                    end
                end
            end
        end
    endgenerate

    // sample buffer; its ready throttles the converters
    sample_fifo #(
        .WIDTH (CH*SW),
        .DEPTH (FIFO_DEPTH),
        .AW    (3)
    ) u_fifo (
        .i_clk         (i_clk),
        .i_reset       (i_reset),
        .i_in_valid    (i_sample_valid),
        .i_in_data     (corrected),
        .o_in_ready_q  (o_sample_ready),
        .o_out_valid_q (o_out_valid),
        .o_out_data    (o_out_data),
        .i_out_ready   (i_out_ready)
    );
endmodule
`default_nettype wire

/* rtl/level_pll_defines.vh */
// register map, field positions, reset values and timing counts for the digitizer control
`ifndef LEVEL_PLL_DEFINES_VH
`define LEVEL_PLL_DEFINES_VH

// subaddresses
`define REG_DIV_UPPER      8'h01
`define REG_DIV_LOWER      8'h02
`define REG_RANGE_PUMP     8'h03
`define REG_PHASE_POST     8'h04
`define REG_LEVEL_CTRL     8'h26
`define REG_LEVEL_PLACE    8'h31
`define REG_COARSE_BASE    8'h40
`define REG_FINE_HI_BASE   8'h43
`define REG_FINE_LO_BASE   8'h46
`define REG_SOURCE_CTRL    8'h50
`define REG_STATUS         8'h51
`define REG_LEVEL_MEAS     8'h52

// field positions
`define DIV_LOWER_MSB      7
`define DIV_LOWER_LSB      4
`define RANGE_MSB          7
`define RANGE_LSB          6
`define PUMP_MSB           5
`define PUMP_LSB           3
`define PHASE_MSB          7
`define PHASE_LSB          3
`define POST_DIV_BIT       0
`define LEVEL_ENABLE_BIT   7
`define SRC_EXT_CLK_BIT    0
`define SRC_SLICED_BIT     1
`define SRC_EXT_CLAMP_BIT  2

// oscillator bands
`define BAND_ULTRA_LOW     2'h0
`define BAND_LOW           2'h1
`define BAND_MEDIUM        2'h2

// reset values
`define RST_DIV_UPPER      8'h32
`define RST_DIV_LOWER      8'h00
`define RST_RANGE_PUMP     8'h20
`define RST_PHASE_POST     8'h80
`define RST_LEVEL_CTRL     8'h00
`define RST_LEVEL_PLACE    8'h10
`define RST_SOURCE_CTRL    8'h00

// timing counts in pixel clocks / samples
`define LEVEL_WIN_SAMPLES  5'h10
`define CLAMP_LEN_CYCLES   8'h08

`endif

/* rtl/sample_fifo.v */
// synchronous fifo for corrected sample words
`timescale 1ns/10ps
`default_nettype none
module sample_fifo #(
    parameter WIDTH = 30,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    // clock and reset
    input  wire             i_clk,
    input  wire             i_reset,
    // fill side
    input  wire             i_in_valid,
    input  wire [WIDTH-1:0] i_in_data,
    output reg              o_in_ready_q,
    // drain side
    output reg              o_out_valid_q,
    output wire [WIDTH-1:0] o_out_data,
    input  wire             i_out_ready
);
    reg  [WIDTH-1:0] mem [0:DEPTH-1];
    reg  [AW-1:0]    wr_q;
    reg  [AW-1:0]    rd_q;
    reg  [AW:0]      count_q;
    reg  [AW:0]      count_d;
    wire             push = i_in_valid & o_in_ready_q;
    wire             pop  = o_out_valid_q & i_out_ready;

    assign o_out_data = mem[rd_q];

    always @* begin
        count_d = count_q;
        if (push & ~pop)
            count_d = count_q + 1'b1;
        else if (pop & ~push)
            count_d = count_q - 1'b1;
    end

    always @(posedge i_clk) begin
        if (push)
            mem[wr_q] <= i_in_data;
    end

    always @(posedge i_clk) begin
        if (i_reset) begin
            wr_q          <= {AW{1'b0}};
            rd_q          <= {AW{1'b0}};
            count_q       <= {(AW+1){1'b0}};
            o_in_ready_q  <= 1'b0;
            o_out_valid_q <= 1'b0;
        end else begin
            if (push)
                wr_q <= (wr_q == DEPTH-1) ? {AW{1'b0}} : wr_q + 1'b1;
            if (pop)
                rd_q <= (rd_q == DEPTH-1) ? {AW{1'b0}} : rd_q + 1'b1;
            count_q       <= count_d;
            // full and empty from the next count, so both flags are honest
            o_in_ready_q  <= (count_d != DEPTH);
            o_out_valid_q <= (count_d != {(AW+1){1'b0}});
        end
    end
endmodule
`default_nettype wire

/* bench/host_bus.sv */
// host serial bus master model for the register port
`timescale 1ns/10ps
`default_nettype none
module host_bus (
    input  wire logic i_clk,
    input  wire logic i_sda_line,
    output var  logic o_scl = 1'b1,
    output var  logic o_sda = 1'b1
);
    localparam logic [6:0] ADDR = 7'h2a; // arbitrary value
    logic nak = 1'b0, a, x;
    // 8 clocks a step, twice the minimum
    task automatic seq(input logic [5:0] p, output logic r);
        for (int i = 4; i >= 0; i -= 2) begin
            {o_scl, o_sda} = p[i+:2];
            repeat (8) @(negedge i_clk);
            if (i == 2) r = i_sda_line;
        end
    endtask
    task automatic bx(input logic [7:0] d, input logic c, output logic [7:0] q);
        for (int i = 7; i >= 0; i--) seq({1'b0, d[i], 1'b1, d[i], 1'b0, d[i]}, q[i]);
        seq(6'h1d, a);
        if (c && a) nak = 1'b1;
    endtask
    task automatic xfer(input logic r, input logic [7:0] s, v, output logic [7:0] q);
        seq(6'h1e, x);
        bx({ADDR, 1'b0}, 1'b1, q);
        bx(s, 1'b1, q);
        if (r) seq(6'h1e, x);
        bx(r ? {ADDR, 1'b1} : v, 1'b1, q);
        if (r) bx(8'hff, 1'b0, q);
        seq(6'h0b, x);
    endtask
endmodule
`default_nettype wire

/* bench/level_pll_ctrl_asserts.sv */
// port assertions for the control block
`timescale 1ns/10ps
`default_nettype none
module level_pll_ctrl_asserts (
    input wire logic        i_clk, i_reset, i_line_hold, i_sample_valid, i_out_ready,
    input wire logic        o_sample_ready, o_out_valid, o_pll_ref_q, o_pll_hold_q,
    input wire logic        o_fine_clamp_q, o_sda_oe_n_q, o_level_pulse_q,
    input wire logic [29:0] o_out_data,
    input wire logic [1:0]  o_band_q
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    sequence s_held; i_line_hold [*4]; endsequence
    property p_hold; s_held |-> o_pll_hold_q; endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_frz; o_pll_hold_q [*2] |-> $stable(o_pll_ref_q); endproperty
    a_frz: assert property (p_frz) else $error("ref");
    property p_clamp; o_pll_hold_q |-> !o_fine_clamp_q; endproperty
    a_clamp: assert property (p_clamp) else $error("clamp");
    property p_band; o_band_q != 2'h3; endproperty
    a_band: assert property (p_band) else $error("band");
    property p_take; i_sample_valid && o_sample_ready |=> o_out_valid; endproperty
    a_take: assert property (p_take) else $error("take");
    property p_head; o_out_valid && !i_out_ready |=> $stable(o_out_data); endproperty
    a_head: assert property (p_head) else $error("head");
    property p_rdy; $fell(i_reset) |=> o_sample_ready; endproperty
    a_rdy: assert property (p_rdy) else $error("ready");
    property p_rst; disable iff (1'b0) i_reset |=> o_sda_oe_n_q && !o_level_pulse_q; endproperty
    a_rst: assert property (p_rst) else $error("reset");
endmodule
bind level_pll_ctrl level_pll_ctrl_asserts i_chk (.*);
`default_nettype wire

/* bench/testbench.sv */
// self-checking bench for the control block
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic i_clk = 0, i_reset = 1, i_hsync_pin = 0, i_line_hold = 0, i_ext_clamp = 0;
    logic i_sample_valid = 0, i_out_ready = 0;
    logic [29:0] i_sample_data = {10'd7, 10'd300, 10'd1000};
    logic [7:0] q;
    int n_errors = 0, tests_run = 0, n = 0;
    wire scl, m_sda, sda = m_sda & i_dut.o_sda_oe_n_q;
    host_bus i_host (.i_clk, .i_sda_line(sda), .o_scl(scl), .o_sda(m_sda));
    level_pll_ctrl i_dut (.i_clk, .i_reset, .i_scl(scl), .i_sda(sda), .o_sda_q(),
        .o_sda_oe_n_q(), .i_hsync_pin, .i_hsync_sliced(i_ext_clamp), .i_line_hold, .i_ext_clamp,
        .i_sample_valid, .i_sample_data, .o_sample_ready(), .o_out_valid(), .o_out_data(),
        .i_out_ready, .o_coarse_offset_q(), .o_feedback_divide_count(), .o_band_q(),
        .o_pump_current_select(), .o_phase_select(), .o_post_divide(), .o_pll_ref_q(),
        .o_ext_pixel_clock(), .o_pll_hold_q(), .o_fine_clamp_q(), .o_level_pulse_q());
    initial forever #2 i_clk = ~i_clk;
    initial begin repeat (40000) @(posedge i_clk); n_errors++; wrap_up; end
    task automatic cyc(input int k); repeat (k) @(negedge i_clk); endtask
    task automatic wr(input logic [7:0] s, v); i_host.xfer(0, s, v, q); endtask
    task automatic chk(input string s, input logic [29:0] e, g);
        tests_run++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", s, e, g);
            n_errors++;
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        cyc(10); i_reset = 0; cyc(3);
        wr(8'h01, 8'ha5); wr(8'h02, 8'hc7); wr(8'h04, 8'hf9); wr(8'h31, 8'h10);
        chk("pll", {12'ha5c, 6'h3f},
            {i_dut.o_feedback_divide_count, i_dut.o_phase_select, i_dut.o_post_divide});
        for (int b = 0; b < 4; b++) begin
            wr(8'h03, {b[1:0], 6'h20});
            chk("band", {b == 3 ? 2'h2 : b[1:0], 3'h4},
                {i_dut.o_band_q, i_dut.o_pump_current_select});
        end
        i_host.xfer(1, 8'h01, 0, q); chk("read", 8'ha5, q);
        i_host.xfer(1, 8'h7f, 0, q); chk("unmapped", 0, q);
        wr(8'h42, 8'h20); chk("coarse", 6'h20, i_dut.o_coarse_offset_q[17:12]);
        wr(8'h43, 8'h01); wr(8'h46, 8'hff); wr(8'h50, 8'h01);
        chk("clock select", 1, i_dut.o_ext_pixel_clock);
        i_sample_valid = 1; cyc(12); chk("full", 0, i_dut.o_sample_ready);
        chk("sat", {10'd7, 10'd300, 10'd1023}, i_dut.o_out_data);
        i_sample_valid = 0; i_out_ready = 1;
        repeat (12) begin n += i_dut.o_out_valid; cyc(1); end
        chk("depth", 8, n); i_out_ready = 0;
        wr(8'h43, 8'h02); wr(8'h46, 8'h00); i_sample_data[9:0] = 5;
        i_sample_valid = 1; cyc(1); i_sample_valid = 0; cyc(2);
        chk("sat low", 0, i_dut.o_out_data[9:0]);
        i_hsync_pin = 1; cyc(5); chk("ref", 1, i_dut.o_pll_ref_q);
        i_line_hold = 1; cyc(5); i_hsync_pin = 0;
        wr(8'h50, 8'h07); wr(8'h26, 8'h80);
        chk("ref held", 1, i_dut.o_pll_ref_q);
        chk("no pulse", 0, i_dut.o_level_pulse_q);
        i_ext_clamp = 1; cyc(8); // long pulse
        chk("clamp held", 0, i_dut.o_fine_clamp_q);
        chk("pulse", 1, i_dut.o_level_pulse_q);
        i_line_hold = 0; cyc(6);
        chk("clamp", 3, {i_dut.o_fine_clamp_q, i_dut.o_pll_ref_q});
        i_out_ready = 1; i_sample_valid = 1; cyc(17); i_out_ready = 0; i_sample_valid = 0;
        cyc(1); chk("loop", 225, i_dut.o_out_data[19:10]);
        chk("ack", 0, i_host.nak);
        wrap_up;
    end
endmodule
`default_nettype wire
